// ### fsim_consts.svh
// Constants for the fault status and interrupt monitor
`ifndef FSIM_CONSTS_SVH
`define FSIM_CONSTS_SVH
// ----------------------------------------
// Clock and timing
// ----------------------------------------
`define FSIM_CLK_HZ          10000000
`define FSIM_SAMPLE_MS       100
`define FSIM_SAMPLE_CYC      ((`FSIM_CLK_HZ / 1000) * `FSIM_SAMPLE_MS)
`define FSIM_PULSE_NS        10000
`define FSIM_PULSE_CYC       ((`FSIM_PULSE_NS * (`FSIM_CLK_HZ / 1000000)) / 1000)
// ----------------------------------------
// Thresholds
// ----------------------------------------
`define FSIM_TH_RESET        10'h3ff
`define FSIM_HYS_RESET       7'h0a
`define FSIM_TH_LIMIT        11'h3fe
// ----------------------------------------
// Warning bit positions
// ----------------------------------------
`define FSIM_W_CONV1_OC      0
`define FSIM_W_CONV2_OC      1
`define FSIM_W_LED_UV        2
`define FSIM_W_LED_OV        3
`define FSIM_W_LED_TW        4
`define FSIM_W_LED_TSD       5
`define FSIM_W_CHIP_TW       6
// ----------------------------------------
// Error bit positions
// ----------------------------------------
`define FSIM_E_CONV2_DESAT   0
`define FSIM_E_LED_DESAT     1
`define FSIM_E_LED_OC        2
`endif

// ### fsim_pkg.sv
// Types for the fault status and interrupt monitor
package fsim_pkg;
  // Interrupt pulse state, Gray coded
  typedef enum logic [1:0]
  {
    FSIM_IRQ_IDLE = 2'b00,
    FSIM_IRQ_LOW  = 2'b01,
    FSIM_IRQ_WAIT = 2'b11
  } fsim_irq_state_t;
endpackage

// ### fsim_hyst_cmp.sv
// One hysteresis comparator for a warning channel
`timescale 1ns/1ps
`include "fsim_consts.svh"
module fsim_hyst_cmp
(
  input  wire logic       i_clk_sys,   // System clock
  input  wire logic       i_rst_b,     // Async reset, active low
  input  wire logic       i_sample,    // New ADC value strobe
  input  wire logic [9:0] i_value,     // Measured value
  input  wire logic [9:0] i_thresh,    // Programmed threshold
  input  wire logic [6:0] i_hyst,      // Programmed hysteresis
  input  wire logic       i_low_side,  // Set for undervoltage direction
  output logic            o_warn       // Warning state
);
  // ----------------------------------------
  // Compare limits
  // ----------------------------------------
  logic [10:0] hi_lim;                 // Threshold plus hysteresis
  logic [10:0] lo_lim;                 // Threshold minus hysteresis
  logic [10:0] val_w;                  // Widened value
  logic        disabled;               // Channel switched off
  logic        warn_q;                 // Held warning
  logic        warn_d;                 // Next warning
  assign hi_lim   = {1'b0, i_thresh} + {4'h0, i_hyst};
  assign lo_lim   = {1'b0, i_thresh} - {4'h0, i_hyst};
  assign val_w    = {1'b0, i_value};
  assign disabled = hi_lim > `FSIM_TH_LIMIT; // RULE_05
  // Low side flips the sense; borrow in lo_lim means never below
  assign warn_d = disabled ? 1'b0 :
                  !i_sample ? warn_q :
                  i_low_side ? (warn_q ? !(val_w > hi_lim)
                                       : (!lo_lim[10] && val_w < lo_lim))
                             : (warn_q ? !(!lo_lim[10] && val_w < lo_lim) // RULE_03
                                       : (val_w > hi_lim)); // RULE_02
  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_rst_b)
  begin
    if (!i_rst_b)
      warn_q <= 1'b0;
    else
      warn_q <= warn_d;
  end
  assign o_warn = warn_q;
endmodule

// ### fsim_status_grp.sv
// Rising and falling capture for one status group
`timescale 1ns/1ps
module fsim_status_grp
#(
  parameter int W = 7                  // Group width
)
(
  input  wire logic         i_clk_sys, // System clock
  input  wire logic         i_rst_b,   // Async reset, active low
  input  wire logic [W-1:0] i_live,    // Live status
  input  wire logic         i_rd_rise, // Clear-on-read rise capture
  input  wire logic         i_rd_fall, // Clear-on-read fall capture
  output logic      [W-1:0] o_live,    // Registered live status
  output logic      [W-1:0] o_rise,    // Rise capture
  output logic      [W-1:0] o_fall     // Fall capture
);
  // ----------------------------------------
  // Edge detection and capture
  // ----------------------------------------
  logic [W-1:0] live_q;                // Last live value
  logic [W-1:0] rise_q;                // Rise capture
  logic [W-1:0] fall_q;                // Fall capture
  logic [W-1:0] rise_ev;               // New rise event
  logic [W-1:0] fall_ev;               // New fall event
  assign rise_ev = i_live & ~live_q;   // RULE_20
  assign fall_ev = ~i_live & live_q;   // RULE_21
  // Set wins over the read clear so no event is lost
  always_ff @(posedge i_clk_sys or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      live_q <= '0;
      rise_q <= '0;
      fall_q <= '0;
    end
    else
    begin
      live_q <= i_live;
      rise_q <= (i_rd_rise ? '0 : rise_q) | rise_ev; // RULE_23
      fall_q <= (i_rd_fall ? '0 : fall_q) | fall_ev; // RULE_23
    end
  end
  assign o_live = live_q;
  assign o_rise = rise_q;
  assign o_fall = fall_q;
endmodule

// ### fsim_top.sv
// Fault supervision and interrupt top level
// ----------------------------------------
// Summary of operation
// RULE_01: Warnings only report, never alter power blocks
// RULE_02: Warning sets above threshold plus hysteresis
// RULE_03: Warning clears below threshold minus hysteresis
// RULE_04: Compare ADC samples taken every 100 ms
// RULE_05: Threshold plus hysteresis above 1022 disables
// RULE_06: Thresholds reset to 1023, warnings off
// RULE_07: Chip thermal warning fixed, always enabled
// RULE_08: LED overvoltage uses threshold plus hysteresis
// RULE_09: Converter overcurrent compares averaged current
// RULE_10: Errors disable the offending block at once
// RULE_11: LED desat holds driver off until enable cleared
// RULE_12: Conv2 desat holds off until enable cleared
// RULE_13: LED overcurrent disables LED until enable cleared
// RULE_14: Thermal shutdown holds all in reset
// RULE_15: Errors group two, warnings group one
// RULE_16: Masked rise or fall capture raises interrupt
// RULE_17: Interrupt open-drain, active low
// RULE_18: Level mode holds line while condition holds
// RULE_19: Pulse mode gives about 10 us low
// RULE_20: Rise capture latches, cleared on read
// RULE_21: Fall capture latches, cleared on read
// RULE_22: Level line low until read and clear
// RULE_23: Event beats simultaneous read clear
// RULE_24: Pulse width timed by clock counter
// ----------------------------------------
`timescale 1ns/1ps
`include "fsim_consts.svh"
module fsim_top
(
  input  wire logic       i_clk_sys,          // 10 MHz system clock
  input  wire logic       i_rst_b,            // Async reset, active low
  input  wire logic [9:0] i_adc_led_temp,     // LED temp pin sample
  input  wire logic [9:0] i_adc_led_volt,     // LED string voltage sample
  input  wire logic [9:0] i_adc_conv1_iavg,   // Conv1 averaged current
  input  wire logic [9:0] i_adc_conv2_iavg,   // Conv2 averaged current
  input  wire logic       i_diag_enable,      // Diagnostics enable
  input  wire logic       i_chip_over_warn,   // Junction above warn limit
  input  wire logic       i_shutdown_hot,     // Junction at high limit
  input  wire logic       i_shutdown_cool,    // Junction below low limit
  input  wire logic       i_led_desat,        // LED desaturation fault
  input  wire logic       i_led_oc,           // LED sense over limit
  input  wire logic       i_conv2_desat,      // Conv2 desaturation fault
  input  wire logic [9:0] i_led_tw_th,        // LED temp warn threshold
  input  wire logic [6:0] i_led_tw_hys,       // LED temp warn hysteresis
  input  wire logic [9:0] i_led_tsd_th,       // LED temp shutdown threshold
  input  wire logic [6:0] i_led_tsd_hys,      // LED temp shutdown hysteresis
  input  wire logic [9:0] i_led_ov_th,        // LED overvolt threshold
  input  wire logic [6:0] i_led_ov_hys,       // LED overvolt hysteresis
  input  wire logic [9:0] i_led_uv_th,        // LED undervolt threshold
  input  wire logic [6:0] i_led_uv_hys,       // LED undervolt hysteresis
  input  wire logic [9:0] i_conv1_oc_th,      // Conv1 overcurrent threshold
  input  wire logic [6:0] i_conv1_oc_hys,     // Conv1 overcurrent hysteresis
  input  wire logic [9:0] i_conv2_oc_th,      // Conv2 overcurrent threshold
  input  wire logic [6:0] i_conv2_oc_hys,     // Conv2 overcurrent hysteresis
  input  wire logic       i_th_wr,            // Threshold write strobe
  input  wire logic       i_led_driver_enable,// Host LED enable bit
  input  wire logic       i_conv2_enable,     // Host conv2 enable bit
  input  wire logic       i_irq_pulse_select, // 1 pulse, 0 level
  input  wire logic [6:0] i_rise_irq_mask_w,  // Warning rise mask
  input  wire logic [2:0] i_rise_irq_mask_e,  // Error rise mask
  input  wire logic [6:0] i_fall_irq_mask_w,  // Warning fall mask
  input  wire logic [2:0] i_fall_irq_mask_e,  // Error fall mask
  input  wire logic       i_rd_rise_w,        // Read rise capture warnings
  input  wire logic       i_rd_rise_e,        // Read rise capture errors
  input  wire logic       i_rd_fall_w,        // Read fall capture warnings
  input  wire logic       i_rd_fall_e,        // Read fall capture errors
  output logic      [6:0] o_live_warning_status, // Live warnings
  output logic      [2:0] o_live_error_status,   // Live errors
  output logic      [6:0] o_rise_capture_warnings, // Rise capture warnings
  output logic      [2:0] o_rise_capture_errors,   // Rise capture errors
  output logic      [6:0] o_fall_capture_warnings, // Fall capture warnings
  output logic      [2:0] o_fall_capture_errors,   // Fall capture errors
  output logic            o_led_run,          // LED driver may run
  output logic            o_conv2_run,        // Conv2 may run
  output logic            o_shutdown,         // Chip held in reset
  output logic            o_irq_out_n,        // Interrupt pin out (always 0)
  output logic            o_irq_oe            // Interrupt pull-low enable
);
  // ----------------------------------------
  // Thermal shutdown hold
  // ----------------------------------------
  logic shut_q;                       // Shutdown held
  logic shut_d;                       // Next shutdown
  logic rst_int_b;                    // Internal reset for the rest
  assign shut_d = i_shutdown_hot ? 1'b1 :
                  i_shutdown_cool ? 1'b0 : shut_q; // RULE_14
  always_ff @(posedge i_clk_sys or negedge i_rst_b)
  begin
    if (!i_rst_b)
      shut_q <= 1'b0;
    else
      shut_q <= shut_d;
  end
  // Gated reset; shut_q is a flop so no glitch reaches the reset tree
  assign rst_int_b = i_rst_b & ~shut_q; // RULE_14

  // ----------------------------------------
  // Sample tick, one per ADC period
  // ----------------------------------------
  localparam int SMP_CYC = `FSIM_SAMPLE_CYC;
  logic [19:0] smp_cnt_q;             // Sample period counter
  logic        smp_tick;              // Compare strobe
  assign smp_tick = i_diag_enable && (smp_cnt_q == 20'h0); // RULE_04
  always_ff @(posedge i_clk_sys or negedge rst_int_b)
  begin
    if (!rst_int_b)
      smp_cnt_q <= 20'h0;
    else if (smp_cnt_q == 20'(SMP_CYC - 1))
      smp_cnt_q <= 20'h0;
    else
      smp_cnt_q <= smp_cnt_q + 20'h1;
  end

  // ----------------------------------------
  // Threshold storage, reset to disabled
  // ----------------------------------------
  logic [9:0] th_q  [6];               // Thresholds per channel
  logic [6:0] hys_q [6];               // Hysteresis per channel
  always_ff @(posedge i_clk_sys or negedge rst_int_b)
  begin
    if (!rst_int_b)
    begin
      for (int i = 0; i < 6; i++)
      begin
        th_q[i]  <= `FSIM_TH_RESET;   // RULE_06
        hys_q[i] <= `FSIM_HYS_RESET;
      end
    end
    else if (i_th_wr)
    begin
      th_q[0]  <= i_conv1_oc_th;
      hys_q[0] <= i_conv1_oc_hys;
      th_q[1]  <= i_conv2_oc_th;
      hys_q[1] <= i_conv2_oc_hys;
      th_q[2]  <= i_led_uv_th;
      hys_q[2] <= i_led_uv_hys;
      th_q[3]  <= i_led_ov_th;
      hys_q[3] <= i_led_ov_hys;
      th_q[4]  <= i_led_tw_th;
      hys_q[4] <= i_led_tw_hys;
      th_q[5]  <= i_led_tsd_th;
      hys_q[5] <= i_led_tsd_hys;
    end
  end

  // ----------------------------------------
  // Programmable warning comparators
  // ----------------------------------------
  logic [9:0] meas [6];               // Measurement per channel
  logic [6:0] warn_live;              // Live warning vector
  assign meas[0] = i_adc_conv1_iavg;  // RULE_09
  assign meas[1] = i_adc_conv2_iavg;  // RULE_09
  assign meas[2] = i_adc_led_volt;
  assign meas[3] = i_adc_led_volt;    // RULE_08
  assign meas[4] = i_adc_led_temp;
  assign meas[5] = i_adc_led_temp;
  for (genvar g = 0; g < 6; g++)
  begin : g_cmp
    fsim_hyst_cmp u_cmp
    (
      .i_clk_sys  (i_clk_sys),
      .i_rst_b    (rst_int_b),
      .i_sample   (smp_tick),
      .i_value    (meas[g]),
      .i_thresh   (th_q[g]),
      .i_hyst     (hys_q[g]),
      .i_low_side (g == `FSIM_W_LED_UV),
      .o_warn     (warn_live[g])
    );
  end
  // Fixed limit, no disable path
  assign warn_live[`FSIM_W_CHIP_TW] = i_chip_over_warn; // RULE_07

  // ----------------------------------------
  // Error latches and power block gating
  // ----------------------------------------
  logic led_lock_q;                   // LED held off after error
  logic conv2_lock_q;                 // Conv2 held off after error
  logic led_run_q;                    // LED run output
  logic conv2_run_q;                  // Conv2 run output
  logic [2:0] err_live;               // Live error vector
  logic led_err;                      // Any LED error now
  assign err_live[`FSIM_E_CONV2_DESAT] = i_conv2_desat;
  assign err_live[`FSIM_E_LED_DESAT]   = i_led_desat;
  assign err_live[`FSIM_E_LED_OC]      = i_led_oc; // RULE_13
  assign led_err = i_led_desat | i_led_oc;
  // Lock releases only when the host drops the enable bit
  always_ff @(posedge i_clk_sys or negedge rst_int_b)
  begin
    if (!rst_int_b)
    begin
      led_lock_q   <= 1'b0;
      conv2_lock_q <= 1'b0;
    end
    else
    begin
      led_lock_q   <= led_err | (led_lock_q & i_led_driver_enable);     // RULE_11
      conv2_lock_q <= i_conv2_desat | (conv2_lock_q & i_conv2_enable); // RULE_12
    end
  end
  // Warnings never enter these terms
  always_ff @(posedge i_clk_sys or negedge rst_int_b)
  begin
    if (!rst_int_b)
    begin
      led_run_q   <= 1'b0;
      conv2_run_q <= 1'b0;
    end
    else
    begin
      led_run_q   <= i_led_driver_enable & ~led_err & ~led_lock_q; // RULE_10 RULE_01
      conv2_run_q <= i_conv2_enable & ~i_conv2_desat & ~conv2_lock_q; // RULE_10
    end
  end

  // ----------------------------------------
  // Status groups
  // ----------------------------------------
  logic [6:0] w_live, w_rise, w_fall; // Warning group
  logic [2:0] e_live, e_rise, e_fall; // Error group
  fsim_status_grp #(.W(7)) u_warn_grp // RULE_15
  (
    .i_clk_sys (i_clk_sys),
    .i_rst_b   (rst_int_b),
    .i_live    (warn_live),
    .i_rd_rise (i_rd_rise_w),
    .i_rd_fall (i_rd_fall_w),
    .o_live    (w_live),
    .o_rise    (w_rise),
    .o_fall    (w_fall)
  );
  fsim_status_grp #(.W(3)) u_err_grp  // RULE_15
  (
    .i_clk_sys (i_clk_sys),
    .i_rst_b   (rst_int_b),
    .i_live    (err_live),
    .i_rd_rise (i_rd_rise_e),
    .i_rd_fall (i_rd_fall_e),
    .o_live    (e_live),
    .o_rise    (e_rise),
    .o_fall    (e_fall)
  );

  // ----------------------------------------
  // Interrupt condition and line drive
  // ----------------------------------------
  localparam int PULSE_CYC = `FSIM_PULSE_CYC;
  logic irq_cond;                     // Any masked capture set
  logic cond_q;                       // Last condition
  logic irq_oe_q;                     // Line pulled low
  logic [7:0] pcnt_q;                 // Pulse width counter
  fsim_pkg::fsim_irq_state_t st_q;    // Pulse state
  assign irq_cond = |(w_rise & i_rise_irq_mask_w) | |(e_rise & i_rise_irq_mask_e) |
                    |(w_fall & i_fall_irq_mask_w) | |(e_fall & i_fall_irq_mask_e); // RULE_16
  // Pulse mode fires on each new assertion of the condition seen while in the idle state
  always_ff @(posedge i_clk_sys or negedge rst_int_b)
  begin
    if (!rst_int_b)
    begin
      st_q     <= fsim_pkg::FSIM_IRQ_IDLE;
      pcnt_q   <= 8'h0;
      cond_q   <= 1'b0;
      irq_oe_q <= 1'b0;
    end
    else
    begin
      cond_q <= irq_cond;
      case (st_q)
        fsim_pkg::FSIM_IRQ_IDLE:
        begin
          if (i_irq_pulse_select && irq_cond && !cond_q)
          begin
            st_q   <= fsim_pkg::FSIM_IRQ_LOW;
            pcnt_q <= 8'(PULSE_CYC - 1); // RULE_24
          end
        end
        fsim_pkg::FSIM_IRQ_LOW:
        begin
          if (pcnt_q == 8'h0)
            st_q <= fsim_pkg::FSIM_IRQ_IDLE;
          else
            pcnt_q <= pcnt_q - 8'h1; // RULE_24
        end
        default:
          st_q <= fsim_pkg::FSIM_IRQ_IDLE;
      endcase
      // Level mode tracks the condition, clearing once a read empties the masked captures
      irq_oe_q <= i_irq_pulse_select ?
                  ((st_q == fsim_pkg::FSIM_IRQ_LOW) && (pcnt_q != 8'h0)) |
                  ((st_q == fsim_pkg::FSIM_IRQ_IDLE) && irq_cond && !cond_q) // RULE_19
                  : irq_cond; // RULE_18 RULE_22
    end
  end

  // ----------------------------------------
  // Output registers
  // ----------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_rst_b)
  begin
    if (!i_rst_b)
      o_irq_out_n <= 1'b0;
    else
      o_irq_out_n <= 1'b0;        // RULE_17
  end
  assign o_irq_oe                = irq_oe_q;  // RULE_17
  assign o_live_warning_status   = w_live;
  assign o_live_error_status     = e_live;
  assign o_rise_capture_warnings = w_rise;
  assign o_rise_capture_errors   = e_rise;
  assign o_fall_capture_warnings = w_fall;
  assign o_fall_capture_errors   = e_fall;
  assign o_led_run               = led_run_q;
  assign o_conv2_run             = conv2_run_q;
  assign o_shutdown              = shut_q;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  sequence s_pulse_start;
    i_irq_pulse_select && irq_cond && !cond_q && st_q == fsim_pkg::FSIM_IRQ_IDLE;
  endsequence
  a_pulse_width: assert property (@(posedge i_clk_sys) disable iff (!rst_int_b) // RULE_19
    s_pulse_start |=> o_irq_oe [*8] ##1 o_irq_oe)
    else $error("pulse interrupt too short");
  a_level_follow: assert property (@(posedge i_clk_sys) disable iff (!rst_int_b) // RULE_18
    !i_irq_pulse_select && $past(!i_irq_pulse_select) |-> o_irq_oe == $past(irq_cond))
    else $error("level interrupt not following condition");
  a_led_lock_hold: assert property (@(posedge i_clk_sys) disable iff (!rst_int_b) // RULE_11
    led_lock_q && i_led_driver_enable |=> !o_led_run)
    else $error("LED ran while locked");
  a_conv2_lock: assert property (@(posedge i_clk_sys) disable iff (!rst_int_b) // RULE_12
    i_conv2_desat |=> !o_conv2_run ##1 (!o_conv2_run || !$past(i_conv2_enable,2)))
    else $error("conv2 not held off");
  a_led_err_off: assert property (@(posedge i_clk_sys) disable iff (!rst_int_b) // RULE_10
    led_err |=> !o_led_run)
    else $error("LED not disabled on error");
  a_rise_keep: assert property (@(posedge i_clk_sys) disable iff (!rst_int_b) // RULE_23
    err_live[0] && !u_err_grp.live_q[0] |=> o_rise_capture_errors[0])
    else $error("rise event lost");
  a_fall_keep: assert property (@(posedge i_clk_sys) disable iff (!rst_int_b) // RULE_21
    !err_live[1] && u_err_grp.live_q[1] |=> o_fall_capture_errors[1])
    else $error("fall event lost");
  a_shut_hold: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b) // RULE_14
    i_shutdown_hot |=> o_shutdown)
    else $error("shutdown not entered");
endmodule

// ### fsim_host_model.sv
// Host side model of the shared open-drain interrupt line
`timescale 1ns/1ps
module fsim_host_model
(
  input  wire logic i_irq_out_n, // Pin data driven by the device
  input  wire logic i_irq_oe,    // Device pulls the line while high
  output logic      o_line       // Resolved line level seen by host
);
  // ----------------------------------------
  // Line resolution
  // ----------------------------------------
  // External pull-up wins whenever the device lets go of the pin
  assign o_line = i_irq_oe ? i_irq_out_n : 1'b1;
endmodule

// ### fault_status_interrupt_monitor_bench.sv
// Self-checking bench for the fault status and interrupt monitor
`timescale 1ns/1ps
`include "fsim_consts.svh"
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin mismatches++; \
  $display("mismatch t=%0t got %h exp %h", $time, a, b); end end
module fault_status_interrupt_monitor_bench;
  // ----------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------
  logic       i_clk_sys = 1'b0, i_rst_b = 1'b0;            // Clock and reset
  logic [9:0] i_adc_led_temp = 10'h010, i_adc_led_volt = 10'h010; // Low readings
  logic [9:0] i_adc_conv1_iavg = 10'h010, i_adc_conv2_iavg = 10'h010;
  logic       i_diag_enable = 1'b1, i_chip_over_warn = 1'b0;
  logic       i_shutdown_hot = 1'b0, i_shutdown_cool = 1'b0;
  logic       i_led_desat = 1'b0, i_led_oc = 1'b0, i_conv2_desat = 1'b0;
  logic [9:0] i_led_tw_th = 10'h3ff, i_led_tsd_th = 10'h3ff, i_led_ov_th = 10'h3ff;
  logic [9:0] i_led_uv_th = 10'h000, i_conv1_oc_th = 10'h3ff, i_conv2_oc_th = 10'h3ff;
  logic [6:0] i_led_tw_hys = 7'h0a, i_led_tsd_hys = 7'h0a, i_led_ov_hys = 7'h0a;
  logic [6:0] i_led_uv_hys = 7'h0a, i_conv1_oc_hys = 7'h0a, i_conv2_oc_hys = 7'h0a;
  logic       i_th_wr = 1'b0, i_led_driver_enable = 1'b0, i_conv2_enable = 1'b0;
  logic       i_irq_pulse_select = 1'b0;                   // Level mode first
  logic [6:0] i_rise_irq_mask_w = 7'h7f, i_fall_irq_mask_w = 7'h00;
  logic [2:0] i_rise_irq_mask_e = 3'h7, i_fall_irq_mask_e = 3'h0;
  logic       i_rd_rise_w = 1'b0, i_rd_rise_e = 1'b0;      // Clear-on-read strobes
  logic       i_rd_fall_w = 1'b0, i_rd_fall_e = 1'b0;
  logic [6:0] o_live_warning_status, o_rise_capture_warnings, o_fall_capture_warnings;
  logic [2:0] o_live_error_status, o_rise_capture_errors, o_fall_capture_errors;
  logic       o_led_run, o_conv2_run, o_shutdown, o_irq_out_n, o_irq_oe;
  logic       irq_line;                                    // Resolved interrupt wire
  int         mismatches = 0, cmp_count = 0, cnt;          // Bookkeeping

  // ----------------------------------------
  // Design, host model and clock
  // ----------------------------------------
  fsim_top DUT (.*);
  fsim_host_model host (.i_irq_out_n(o_irq_out_n), .i_irq_oe(o_irq_oe), .o_line(irq_line));
  // 10 MHz system clock
  always #50 i_clk_sys = ~i_clk_sys;

  // ----------------------------------------
  // Access tasks
  // ----------------------------------------
  // All stimulus changes land on the falling edge
  task automatic wait_n(input int n);
    repeat (n) @(negedge i_clk_sys);
  endtask
  // Drive one error input by its status bit position
  task automatic set_err(input int e, input logic v);
    case (e)
      0: i_conv2_desat = v;
      1: i_led_desat = v;
      default: i_led_oc = v;
    endcase
  endtask
  // Clear-on-read of both error capture registers
  task automatic read_errs();
    i_rd_rise_e = 1'b1;
    i_rd_fall_e = 1'b1;
    wait_n(1);
    i_rd_rise_e = 1'b0;
    i_rd_fall_e = 1'b0;
  endtask
  // Host drops the enable bits for one cycle to release a lockout
  task automatic reenable();
    {i_led_driver_enable, i_conv2_enable} = 2'b00;
    wait_n(1);
    {i_led_driver_enable, i_conv2_enable} = 2'b11;
    wait_n(4);
  endtask
  // Bring one error back to a quiet state
  task automatic tidy(input int e);
    set_err(e, 1'b0);
    wait_n(4);
    read_errs();
    reenable();
  endtask
  // Single place where the run ends
  task automatic finish_test();
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    wait_n(5);
    i_rst_b = 1'b1;
    wait_n(2);
    `CHK(o_rise_capture_errors, 3'h0)
    `CHK(irq_line, 1'b1)
    i_th_wr = 1'b1;
    wait_n(1);
    i_th_wr = 1'b0;
    {i_led_driver_enable, i_conv2_enable} = 2'b11;
    wait_n(4);
    // Each error: lockout, capture, level line and host release
    for (int e = 0; e < 3; e++)
    begin
      `CHK((e == 0) ? o_conv2_run : o_led_run, 1'b1)
      set_err(e, 1'b1);
      wait_n(4);
      `CHK((e == 0) ? o_conv2_run : o_led_run, 1'b0)
      `CHK(o_live_error_status[e], 1'b1)
      `CHK(o_rise_capture_errors[e], 1'b1)
      `CHK(irq_line, 1'b0)
      set_err(e, 1'b0);
      wait_n(4);
      `CHK((e == 0) ? o_conv2_run : o_led_run, 1'b0)
      `CHK(o_fall_capture_errors[e], 1'b1)
      `CHK(irq_line, 1'b0)
      read_errs();
      wait_n(4);
      `CHK(o_rise_capture_errors[e], 1'b0)
      `CHK(irq_line, 1'b1)
      reenable();
      `CHK((e == 0) ? o_conv2_run : o_led_run, 1'b1)
      $display("test error %0d done", e);
    end
    // Edge event lands on the same edge as the clearing read
    set_err(1, 1'b1);
    i_rd_rise_e = 1'b1;
    wait_n(1);
    i_rd_rise_e = 1'b0;
    wait_n(2);
    `CHK(o_rise_capture_errors[1], 1'b1)
    tidy(1);
    $display("test read collision done");
    // Pulse mode: count low cycles over a bounded window
    i_irq_pulse_select = 1'b1;
    set_err(2, 1'b1);
    cnt = 0;
    for (int k = 0; k < 300; k++)
    begin
      wait_n(1);
      if (irq_line !== 1'b1)
        cnt++;
    end
    `CHK(cnt, `FSIM_PULSE_CYC)
    tidy(2);
    i_irq_pulse_select = 1'b0;
    $display("test pulse done");
    // Chip thermal warning reports and interrupts, power blocks untouched
    i_chip_over_warn = 1'b1;
    wait_n(4);
    `CHK(o_live_warning_status, 7'h40)
    `CHK(o_rise_capture_warnings[6], 1'b1)
    `CHK(irq_line, 1'b0)
    `CHK({o_led_run, o_conv2_run}, 2'b11)
    i_chip_over_warn = 1'b0;
    wait_n(4);
    `CHK(o_fall_capture_warnings[6], 1'b1)
    {i_rd_rise_w, i_rd_fall_w} = 2'b11;
    wait_n(1);
    {i_rd_rise_w, i_rd_fall_w} = 2'b00;
    wait_n(2);
    `CHK({o_rise_capture_warnings, o_fall_capture_warnings}, 14'h0000)
    `CHK(irq_line, 1'b1)
    $display("test chip warning done");
    // Thermal shutdown holds everything off until cool
    i_shutdown_hot = 1'b1;
    wait_n(4);
    `CHK(o_shutdown, 1'b1)
    `CHK(o_led_run, 1'b0)
    // Full-scale readings meet the first compare after the internal reset
    {i_adc_led_temp, i_adc_led_volt} = {10'h3ff, 10'h3ff};
    {i_adc_conv1_iavg, i_adc_conv2_iavg} = {10'h3ff, 10'h3ff};
    i_shutdown_hot = 1'b0;
    i_shutdown_cool = 1'b1;
    wait_n(4);
    `CHK(o_shutdown, 1'b0)
    `CHK(o_live_warning_status, 7'h00)
    i_shutdown_cool = 1'b0;
    $display("test shutdown done");
    finish_test();
  end
endmodule
